//--- common/vrc_cfg.svh
/*
 * Constants of the page-1 configuration bank: offsets, field ranges,
 * write masks, fixed bit values and timing counts.
 * Assumes a 20 MHz core clock and a management-bus decoder that hands
 * over one register access at a time together with the selected page.
 */
// How it works
// RL1 - Hold four 4-bit rail-2 trims for 4,3,2,1-phase operation, 2.3 mV steps.
// RL2 - Decode 3-bit rail-2 stage sense gain; codes above 100 are invalid.
// RL3 - Reserved bits ignore writes and always read as zero.
// RL4 - Each 4-bit select picks slot 18h-1Fh, page 0 for 0-7, page 1 for 8-15.
// RL5 - Select register holds rail-2 droop, rail-2 monitor, rail-1 droop, rail-1 monitor.
// RL6 - Host picks each slot to suit the monitor resistor and gain in use.
// RL7 - The fixed PWM routing register always reads 0xFFFF.
// RL8 - Bit 11 enables imbalance-based faulty phase detection.
// RL9 - A phase held below the low sense limit for the interval is abnormal.
// RL10 - Interval counts 2 us steps when scale bit is one, else 20 us.
// RL11 - Bit 5 sets both rail enable inputs active high or active low.
// RL12 - Bits 4:2 route one of eight sources to the power-good pin.
// RL13 - Bit 0 selects independent or coupled inductor shedding behaviour.
// RL14 - Bit 15 enables blocking of sense ripple detection by input voltage.
// RL15 - Ripple detection is off while input voltage is under 8, 9, 10 or 11 V.
// RL16 - Target under the minimum level ramps that rail to zero, drops power good.
// RL17 - Converter output under the shutdown level puts the rail PWM into Hi-Z.
// RL18 - The Hi-Z shutdown level acts only while slewing down to zero.
// RL19 - Minimum and shutdown levels count in VID steps from the loop control.
// RL20 - Bits 6:0 limit adaptive-bus slew; resolution comes from a separate bit.
// RL21 - Slope register: 5-bit peak, 7-bit current, bits 8:5 fixed to one.
// RL22 - DCM slope register: 4-bit capacitor at 9:6, 6-bit current at 5:0.
// RL23 - Bit 15 of the adaptive setup enables adaptive-voltage bus mode.
// RL24 - Adaptive high and low thresholds are 6-bit fields, 40 mV steps.
// RL25 - Accesses at these offsets reach the bank only with page 1 selected.
`ifndef VRC_CFG_SVH
`define VRC_CFG_SVH

`define VRC_PAGE            1'b1
`define VRC_OFS_SLOPE_PEAK  8'hBF
`define VRC_OFS_TRIMS       8'hC0
`define VRC_OFS_DCM         8'hC1
`define VRC_OFS_SLOT_SEL    8'hC2
`define VRC_OFS_ROUTE       8'hC3
`define VRC_OFS_REDUND      8'hC4
`define VRC_OFS_SHUTDOWN    8'hC5
`define VRC_OFS_SLEW        8'hC6
`define VRC_OFS_AVS         8'hC7

`define VRC_WM_FULL         16'hFFFF
`define VRC_WM_DCM          16'h1FFF
`define VRC_WM_ROUTE        16'h0000
`define VRC_WM_REDUND       16'h0FBD
`define VRC_WM_SLEW         16'h007F
`define VRC_WM_AVS          16'hDFFF
`define VRC_WM_PEAK         16'hFE1F
`define VRC_FIX_ROUTE       16'hFFFF
`define VRC_FIX_REDUND      16'hF000
`define VRC_FIX_AVS         16'h2000
`define VRC_FIX_PEAK        16'h01E0
`define VRC_ZERO16          16'h0000

`define VRC_F_PEAK_LVL      4:0
`define VRC_F_PEAK_CUR      15:9
`define VRC_F_GAIN          12:10
`define VRC_F_CAP           9:6
`define VRC_F_DCM_CUR       5:0
`define VRC_B_IMBAL         11
`define VRC_F_INTERVAL      10:7
`define VRC_B_POLARITY      5
`define VRC_F_PG_SEL        4:2
`define VRC_B_COUPLED       0
`define VRC_B_BLOCK_EN      15
`define VRC_F_BLOCK_TH      14:13
`define VRC_F_MIN_LVL       12:8
`define VRC_F_HIZ_LVL       7:0
`define VRC_F_SLEW          6:0
`define VRC_B_AVS_EN        15
`define VRC_F_AVS_HIGH      11:6
`define VRC_F_AVS_LOW       5:0

`define VRC_BLOCK_BASE_V    5'h08
`define VRC_SLOT_BASE       8'h18
`define VRC_PHASES          4

`define VRC_CLK_PERIOD_NS   50
`define VRC_FAST_STEP_US    2
`define VRC_SLOW_STEP_US    20
`define VRC_FAST_CYC ((`VRC_FAST_STEP_US*1000+`VRC_CLK_PERIOD_NS-1)/`VRC_CLK_PERIOD_NS)
`define VRC_SLOW_CYC ((`VRC_SLOW_STEP_US*1000+`VRC_CLK_PERIOD_NS-1)/`VRC_CLK_PERIOD_NS)

`endif

//--- common/vrc_pkg.sv
/*
 * Types shared by the page-1 configuration bank.
 * Assumes vrc_cfg.svh supplies the constants.
 */
`include "vrc_cfg.svh"
package vrc_pkg;
	typedef logic [15:0] vrc_word_t;
	typedef logic [10:0] vrc_vid_t;
	typedef enum logic [2:0] {
		VRC_PG_FORCE   = 3'h0,
		VRC_PG_FAULT   = 3'h1,
		VRC_PG_RAIL    = 3'h2,
		VRC_PG_OC      = 3'h3,
		VRC_PG_STAGE   = 3'h4,
		VRC_PG_OCWARN  = 3'h5,
		VRC_PG_HOT     = 3'h6,
		VRC_PG_INTERN  = 3'h7
	} vrc_pg_src_t;
	typedef enum logic [2:0] {
		VRC_G5   = 3'h0,
		VRC_G8P5 = 3'h1,
		VRC_G9   = 3'h2,
		VRC_G9P7 = 3'h3,
		VRC_G10  = 3'h4
	} vrc_gain_t;
endpackage

//--- design/vrc_bank.sv
/*
 * Page-1 configuration bank: stored registers BFh, C0h to C2h and C4h to C7h, fixed C3h, and the
 * small amount of logic that those fields steer directly.
 * Assumes a management-bus decoder in the same clock domain that presents
 * one-cycle read or write strobes with page, offset and data; comparator
 * and VID inputs come from core logic, enable pins come from outside.
 */
`include "vrc_cfg.svh"
module vrc_bank
	import vrc_pkg::*;
(
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	input  wire logic                     reg_wr_i,
	input  wire logic                     reg_rd_i,
	input  wire logic                     reg_page_i,
	input  wire logic [7:0]               reg_addr_i,
	input  wire logic [15:0]              reg_wdata_i,
	output logic      [15:0]              reg_rdata_o,
	output logic                          reg_rd_valid_o,
	input  wire logic [1:0]               rail_en_pin_i,
	input  wire logic [`VRC_PHASES-1:0]   phase_cs_low_i,
	input  wire logic                     detect_time_scale_select_i,
	input  wire logic                     pin_force_level_i,
	input  wire logic                     fault_flag_n_i,
	input  wire logic                     rail_sel_good_i,
	input  wire logic                     overcurrent_flag_n_i,
	input  wire logic                     power_stage_fault_n_i,
	input  wire logic                     overcurrent_warn_n_i,
	input  wire logic                     regulator_hot_n_i,
	input  wire logic                     internal_good_i,
	input  wire logic [4:0]               vin_volts_i,
	input  wire logic [1:0]               voltage_code_step_i,
	input  wire logic [1:0][10:0]         target_vid_i,
	input  wire logic [1:0][10:0]         dac_vid_i,
	input  wire logic [1:0]               slewing_to_zero_i,
	input  wire logic                     slew_resolution_bit_i,
	output logic      [1:0]               rail_enable_o,
	output logic      [`VRC_PHASES-1:0]   phase_abnormal_o,
	output logic                          good_pin_o,
	output logic                          ripple_detect_enable_o,
	output logic      [1:0]               rail_ramp_off_o,
	output logic      [1:0]               rail_good_block_o,
	output logic      [1:0]               pwm_hiz_o,
	output logic      [15:0]              rail2_trims_o,
	output logic      [7:0]               rail2_sense_gain_o,
	output logic                          sense_gain_valid_o,
	output logic      [3:0]               slot_page_o,
	output logic      [3:0][7:0]          slot_addr_o,
	output logic                          inductor_coupled_o,
	output logic                          adaptive_bus_enable_o,
	output logic      [5:0]               adaptive_high_threshold_o,
	output logic      [5:0]               adaptive_low_threshold_o,
	output logic      [6:0]               transition_slew_limit_o,
	output logic                          slew_resolution_o,
	output logic      [4:0]               rail2_slope_peak_level_o,
	output logic      [6:0]               rail2_slope_current_qty_o,
	output logic      [3:0]               slope_capacitor_value_o,
	output logic      [5:0]               dcm_current_source_o
);

	typedef struct packed {
		vrc_word_t                  peak;
		vrc_word_t                  trims;
		vrc_word_t                  dcm;
		vrc_word_t                  slot_sel;
		vrc_word_t                  redund;
		vrc_word_t                  shutdown;
		vrc_word_t                  slew;
		vrc_word_t                  avs;
		logic [15:0]                rdata;
		logic                       rd_valid;
		logic [1:0]                 en_s1;
		logic [1:0]                 en_s2;
		logic [1:0]                 en_s3;
		logic [1:0]                 en_level;
		logic [`VRC_PHASES-1:0][8:0] pre_cnt;
		logic                       tick_scale;
		logic [`VRC_PHASES-1:0][3:0] ph_cnt;
		logic [`VRC_PHASES-1:0]     abnormal;
		logic [1:0]                 rail_en;
		logic                       good_pin;
		logic                       ripple_en;
		logic [1:0]                 ramp_off;
		logic [1:0]                 hiz;
		logic [7:0]                 gain;
		logic                       gain_valid;
		logic [3:0][7:0]            slot_addr;
		logic [3:0]                 slot_page;
		logic                       slew_res;
	} vrc_state_t;

	vrc_state_t st;
	vrc_state_t next_st;

	logic [8:0]  tick_last;
	logic        sel_page;
	vrc_word_t   rd_word;
	vrc_word_t   wr_masked;
	vrc_vid_t    min_level [2];
	vrc_vid_t    hiz_level [2];
	logic [4:0]  block_th;

	assign sel_page  = (reg_page_i == `VRC_PAGE);
	assign tick_last = st.tick_scale ? 9'(`VRC_FAST_CYC - 1)
	                                 : 9'(`VRC_SLOW_CYC - 1);
	assign block_th  = `VRC_BLOCK_BASE_V + 5'(st.shutdown[`VRC_F_BLOCK_TH]);

	// Both levels scale by the Voltage_code_step so they compare in base units.
	always_comb begin
		for (int r = 0; r < 2; r++) begin
			min_level[r] = 11'(st.shutdown[`VRC_F_MIN_LVL])
			               << voltage_code_step_i; // [RL19]
			hiz_level[r] = 11'(st.shutdown[`VRC_F_HIZ_LVL])
			               << voltage_code_step_i; // [RL19]
		end
	end

	// Read value: stored writable bits merged with fixed bits.
	always_comb begin
		case (reg_addr_i)
			`VRC_OFS_SLOPE_PEAK: rd_word = st.peak | `VRC_FIX_PEAK; // [RL21]
			`VRC_OFS_TRIMS:      rd_word = st.trims;
			`VRC_OFS_DCM:        rd_word = st.dcm;
			`VRC_OFS_SLOT_SEL:   rd_word = st.slot_sel;
			`VRC_OFS_ROUTE:      rd_word = `VRC_FIX_ROUTE; // [RL7]
			`VRC_OFS_REDUND:     rd_word = st.redund | `VRC_FIX_REDUND;
			`VRC_OFS_SHUTDOWN:   rd_word = st.shutdown;
			`VRC_OFS_SLEW:       rd_word = st.slew;
			`VRC_OFS_AVS:        rd_word = st.avs | `VRC_FIX_AVS;
			default:             rd_word = `VRC_ZERO16;
		endcase
	end

	// Write value: reserved and fixed positions are dropped here.
	always_comb begin
		case (reg_addr_i)
			`VRC_OFS_SLOPE_PEAK: wr_masked = reg_wdata_i & `VRC_WM_PEAK;
			`VRC_OFS_DCM:        wr_masked = reg_wdata_i & `VRC_WM_DCM;
			`VRC_OFS_ROUTE:      wr_masked = reg_wdata_i & `VRC_WM_ROUTE;
			`VRC_OFS_REDUND:     wr_masked = reg_wdata_i & `VRC_WM_REDUND;
			`VRC_OFS_SLEW:       wr_masked = reg_wdata_i & `VRC_WM_SLEW;
			`VRC_OFS_AVS:        wr_masked = reg_wdata_i & `VRC_WM_AVS;
			default:             wr_masked = reg_wdata_i & `VRC_WM_FULL;
		endcase // [RL3]
	end

	always_comb begin
		next_st = st;

		// Register access, honoured only with page 1 selected.
		next_st.rd_valid = reg_rd_i;
		if (reg_rd_i) begin
			next_st.rdata = sel_page ? rd_word : `VRC_ZERO16; // [RL25]
		end
		if (reg_wr_i && sel_page) begin // [RL25]
			case (reg_addr_i)
				`VRC_OFS_SLOPE_PEAK: next_st.peak     = wr_masked; // [RL21]
				`VRC_OFS_TRIMS:      next_st.trims    = wr_masked; // [RL1]
				`VRC_OFS_DCM:        next_st.dcm      = wr_masked; // [RL22]
				`VRC_OFS_SLOT_SEL:   next_st.slot_sel = wr_masked; // [RL5]
				`VRC_OFS_REDUND:     next_st.redund   = wr_masked;
				`VRC_OFS_SHUTDOWN:   next_st.shutdown = wr_masked;
				`VRC_OFS_SLEW:       next_st.slew     = wr_masked; // [RL20]
				`VRC_OFS_AVS:        next_st.avs      = wr_masked; // [RL24]
				default:             next_st.avs      = st.avs;
			endcase
		end

		// Enable pins: a change counts once the second and third agree.
		next_st.en_s1 = rail_en_pin_i;
		next_st.en_s2 = st.en_s1;
		next_st.en_s3 = st.en_s2;
		for (int r = 0; r < 2; r++) begin
			if (st.en_s2[r] == st.en_s3[r]) begin
				next_st.en_level[r] = st.en_s3[r];
			end
		end
		next_st.rail_en = st.en_level
		                  ^ {2{st.redund[`VRC_B_POLARITY]}}; // [RL11]

		// Each phase times its own low spell from its start, so a phase is
		// flagged only after the whole interval has passed.
		// A change of step scale restarts the step timers.
		next_st.tick_scale = detect_time_scale_select_i;
		for (int p = 0; p < `VRC_PHASES; p++) begin
			if (!phase_cs_low_i[p] || !st.redund[`VRC_B_IMBAL]) begin
				next_st.pre_cnt[p] = 9'h000;
				next_st.ph_cnt[p]  = 4'h0; // [RL8]
			end else if (st.tick_scale != detect_time_scale_select_i) begin
				next_st.pre_cnt[p] = 9'h000;
			end else if (st.pre_cnt[p] == tick_last) begin
				next_st.pre_cnt[p] = 9'h000; // [RL10]
				if (st.ph_cnt[p] < st.redund[`VRC_F_INTERVAL]) begin
					next_st.ph_cnt[p] = st.ph_cnt[p] + 4'h1; // [RL9]
				end
			end else begin
				next_st.pre_cnt[p] = st.pre_cnt[p] + 9'h001; // [RL10]
			end
			next_st.abnormal[p] = st.redund[`VRC_B_IMBAL] &&
			                      phase_cs_low_i[p] &&
			                      st.ph_cnt[p] >=
			                      st.redund[`VRC_F_INTERVAL]; // [RL9]
		end

		// Power-good pin source.
		case (vrc_pg_src_t'(st.redund[`VRC_F_PG_SEL]))
			VRC_PG_FORCE:  next_st.good_pin = pin_force_level_i; // [RL12]
			VRC_PG_FAULT:  next_st.good_pin = fault_flag_n_i;
			VRC_PG_RAIL:   next_st.good_pin = rail_sel_good_i;
			VRC_PG_OC:     next_st.good_pin = overcurrent_flag_n_i;
			VRC_PG_STAGE:  next_st.good_pin = power_stage_fault_n_i;
			VRC_PG_OCWARN: next_st.good_pin = overcurrent_warn_n_i;
			VRC_PG_HOT:    next_st.good_pin = regulator_hot_n_i;
			VRC_PG_INTERN: next_st.good_pin = internal_good_i;
			default:       next_st.good_pin = internal_good_i;
		endcase

		next_st.ripple_en = !(st.shutdown[`VRC_B_BLOCK_EN] && // [RL14]
		                      vin_volts_i < block_th); // [RL15]

		for (int r = 0; r < 2; r++) begin
			next_st.ramp_off[r] = target_vid_i[r] < min_level[r]; // [RL16]
			next_st.hiz[r]      = slewing_to_zero_i[r] && // [RL18]
			                      dac_vid_i[r] < hiz_level[r]; // [RL17]
		end

		// Sense gain in tenths of a microamp per amp.
		next_st.gain_valid = 1'b1;
		case (vrc_gain_t'(st.dcm[`VRC_F_GAIN]))
			VRC_G5:   next_st.gain = 8'h32; // [RL2]
			VRC_G8P5: next_st.gain = 8'h55;
			VRC_G9:   next_st.gain = 8'h5A;
			VRC_G9P7: next_st.gain = 8'h61;
			VRC_G10:  next_st.gain = 8'h64;
			default: begin
				next_st.gain       = 8'h00;
				next_st.gain_valid = 1'b0;
			end
		endcase

		// Backup slot decode: top bit gives the page, low three the slot.
		for (int s = 0; s < 4; s++) begin
			next_st.slot_page[s] = st.slot_sel[4*s+3]; // [RL4]
			next_st.slot_addr[s] = `VRC_SLOT_BASE
			                       + 8'(st.slot_sel[4*s +: 3]); // [RL4]
		end

		next_st.slew_res = slew_resolution_bit_i; // [RL20]
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st          <= '0;
			st.en_level <= 2'h0;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata_o               = st.rdata;
	assign reg_rd_valid_o            = st.rd_valid;
	assign rail_enable_o             = st.rail_en;
	assign phase_abnormal_o          = st.abnormal;
	assign good_pin_o                = st.good_pin;
	assign ripple_detect_enable_o    = st.ripple_en;
	assign rail_ramp_off_o           = st.ramp_off;
	assign rail_good_block_o         = st.ramp_off; // [RL16]
	assign pwm_hiz_o                 = st.hiz;
	assign rail2_trims_o             = st.trims; // [RL1]
	assign rail2_sense_gain_o        = st.gain;
	assign sense_gain_valid_o        = st.gain_valid;
	assign slot_page_o               = st.slot_page;
	assign slot_addr_o               = st.slot_addr;
	assign inductor_coupled_o        = st.redund[`VRC_B_COUPLED]; // [RL13]
	assign adaptive_bus_enable_o     = st.avs[`VRC_B_AVS_EN]; // [RL23]
	assign adaptive_high_threshold_o = st.avs[`VRC_F_AVS_HIGH]; // [RL24]
	assign adaptive_low_threshold_o  = st.avs[`VRC_F_AVS_LOW];
	assign transition_slew_limit_o   = st.slew[`VRC_F_SLEW];
	assign slew_resolution_o         = st.slew_res;
	assign rail2_slope_peak_level_o  = st.peak[`VRC_F_PEAK_LVL];
	assign rail2_slope_current_qty_o = st.peak[`VRC_F_PEAK_CUR];
	assign slope_capacitor_value_o   = st.dcm[`VRC_F_CAP];
	assign dcm_current_source_o      = st.dcm[`VRC_F_DCM_CUR]; // [RL22]

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_read_at(logic [7:0] ofs);
		reg_rd_i && sel_page && reg_addr_i == ofs;
	endsequence

	property p_slew_reserved;
		s_read_at(`VRC_OFS_SLEW) |=> reg_rd_valid_o && reg_rdata_o[15:7] == 9'h000;
	endproperty
	a_slew_reserved: assert property (p_slew_reserved) // [RL3]
		else $error("Reserved slew bits read nonzero");

	property p_route_fixed;
		s_read_at(`VRC_OFS_ROUTE) |=> reg_rdata_o == 16'hFFFF;
	endproperty
	a_route_fixed: assert property (p_route_fixed) // [RL7]
		else $error("Routing register not 0xFFFF");

	property p_peak_fixed;
		s_read_at(`VRC_OFS_SLOPE_PEAK) |=> reg_rdata_o[8:5] == 4'hF;
	endproperty
	a_peak_fixed: assert property (p_peak_fixed) // [RL21]
		else $error("Slope fixed bits not one");

	property p_page_guard;
		(reg_wr_i && !sel_page) |=> $stable(st.trims) && $stable(st.avs);
	endproperty
	a_page_guard: assert property (p_page_guard) // [RL25]
		else $error("Write on wrong page changed the bank");

	property p_polarity;
		$stable(st.redund) && $stable(st.en_level)
		|=> rail_enable_o == ($past(st.en_level)
		                      ^ {2{$past(st.redund[`VRC_B_POLARITY])}});
	endproperty
	a_polarity: assert property (p_polarity) // [RL11]
		else $error("Rail enable polarity wrong");

	property p_pg_fault;
		st.redund[`VRC_F_PG_SEL] == 3'h1 |=> good_pin_o == $past(fault_flag_n_i);
	endproperty
	a_pg_fault: assert property (p_pg_fault) // [RL12]
		else $error("Power-good pin not showing fault flag");

	property p_detect_off;
		!st.redund[`VRC_B_IMBAL] |=> phase_abnormal_o == '0;
	endproperty
	a_detect_off: assert property (p_detect_off) // [RL8]
		else $error("Abnormal phase with detection disabled");

	// Two cycles of low sense with detection on and a zero interval.
	sequence s_low_two;
		(st.redund[`VRC_B_IMBAL] && st.redund[`VRC_F_INTERVAL] == 4'h0 &&
		 phase_cs_low_i[0]) [*2];
	endsequence

	property p_abnormal_cause;
		phase_abnormal_o[0] |-> $past(phase_cs_low_i[0]);
	endproperty
	a_abnormal_cause: assert property (p_abnormal_cause) // [RL9]
		else $error("Abnormal without low sense");

	property p_zero_interval;
		s_low_two |=> phase_abnormal_o[0];
	endproperty
	a_zero_interval: assert property (p_zero_interval) // [RL9]
		else $error("Zero interval did not flag at once");

	property p_ripple;
		st.shutdown[15] && vin_volts_i < 5'h08 |=> !ripple_detect_enable_o;
	endproperty
	a_ripple: assert property (p_ripple) // [RL15]
		else $error("Ripple detection kept under threshold");

	property p_vid_off;
		target_vid_i[0] < min_level[0] |=> rail_ramp_off_o[0] && rail_good_block_o[0];
	endproperty
	a_vid_off: assert property (p_vid_off) // [RL16]
		else $error("Rail not ramped off under minimum");

	property p_hiz_only_slewing;
		!slewing_to_zero_i[1] |=> !pwm_hiz_o[1];
	endproperty
	a_hiz_only_slewing: assert property (p_hiz_only_slewing) // [RL18]
		else $error("Hi-Z outside slew to zero");

	property p_gain_invalid;
		st.dcm[12] && st.dcm[11:10] != 2'h0 |=> !sense_gain_valid_o;
	endproperty
	a_gain_invalid: assert property (p_gain_invalid) // [RL2]
		else $error("Invalid gain code accepted");

endmodule // vrc_bank

//--- dv/tb.sv
/*
 * Bench of the page-1 bank: register access through the host model, then
 * the outputs that the fields steer. Assumes vrc_bank and vrc_host.
 */
`include "vrc_cfg.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, reset_i, reg_wr_i, reg_rd_i, reg_page_i, reg_rd_valid_o;
	logic [7:0] reg_addr_i, rail2_sense_gain_o, pgs;
	logic [15:0] reg_wdata_i, reg_rdata_o, rail2_trims_o, d, q[$], v[9];
	logic [1:0] rail_en_pin_i, voltage_code_step_i, slewing_to_zero_i;
	logic [1:0] rail_enable_o, rail_ramp_off_o, rail_good_block_o, pwm_hiz_o;
	logic [`VRC_PHASES-1:0] phase_cs_low_i, phase_abnormal_o;
	logic detect_time_scale_select_i, slew_resolution_bit_i, good_pin_o;
	logic ripple_detect_enable_o, sense_gain_valid_o, inductor_coupled_o;
	logic adaptive_bus_enable_o, slew_resolution_o;
	logic [4:0] vin_volts_i, rail2_slope_peak_level_o;
	logic [1:0][10:0] target_vid_i, dac_vid_i;
	logic [3:0] slot_page_o, slope_capacitor_value_o;
	logic [3:0][7:0] slot_addr_o;
	logic [5:0] adaptive_high_threshold_o, adaptive_low_threshold_o;
	logic [5:0] dcm_current_source_o;
	logic [6:0] transition_slew_limit_o, rail2_slope_current_qty_o;
	logic [10:0] lim;
	wire logic pin_force_level_i = pgs[0], fault_flag_n_i = pgs[1];
	wire logic rail_sel_good_i = pgs[2], overcurrent_flag_n_i = pgs[3];
	wire logic power_stage_fault_n_i = pgs[4], overcurrent_warn_n_i = pgs[5];
	wire logic regulator_hot_n_i = pgs[6], internal_good_i = pgs[7];
	int n_fail, checks_done, seed, i, k;
	logic [7:0] ofs[9] = '{8'hBF, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5,
		8'hC6, 8'hC7};
	logic [15:0] wm[9] = '{16'hFE1F, 16'hFFFF, 16'h1FFF, 16'hFFFF, 16'h0000,
		16'h0FBD, 16'hFFFF, 16'h007F, 16'hDFFF};
	logic [15:0] fx[9] = '{16'h01E0, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF,
		16'hF000, 16'h0000, 16'h0000, 16'h2000};
	logic [7:0] gt[8] = '{8'h32, 8'h55, 8'h5A, 8'h61, 8'h64, 8'h00, 8'h00,
		8'h00};

	vrc_bank i_vrc_bank (.*);
	vrc_host i_vrc_host (.clk_i(clk_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
		.page_o(reg_page_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] dd);
		i_vrc_host.access(1'b1, 1'b1, a, dd);
	endtask
	task automatic rd(input logic p, input logic [7:0] a, input logic [15:0] e);
		q.push_back(e);
		i_vrc_host.access(1'b0, p, a, 16'h0000);
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic final_report;
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Every read answer is matched against the oldest noted expectation.
	always @(negedge clk_i) begin
		if (reg_rd_valid_o === 1'b1) begin
			if (q.size() == 0)
				chk(reg_rdata_o, 16'hXXXX);
			else
				chk(reg_rdata_o, q.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		final_report();
	end
	initial begin
		seed = 32'hFCBE;
		n_fail = 0;
		checks_done = 0;
		{reset_i, detect_time_scale_select_i, slew_resolution_bit_i} = 3'h7;
		{rail_en_pin_i, voltage_code_step_i, slewing_to_zero_i} = 6'h00;
		{phase_cs_low_i, pgs, vin_volts_i} = 17'h00000;
		{target_vid_i, dac_vid_i} = 44'h000_0000_0000;
		tick(10);
		reset_i = 1'b0;
		for (i = 0; i < 9; i++)
			rd(1'b1, ofs[i], fx[i]);
		for (i = 0; i < 9; i++) begin
			d = $random(seed);
			v[i] = (d & wm[i]) | fx[i];
			wr(ofs[i], d);
			rd(1'b1, ofs[i], v[i]);
		end
		tick(2);
		chk(rail2_trims_o, v[1]);
		chk({rail2_slope_current_qty_o, 4'hF, rail2_slope_peak_level_o},
			v[0]);
		chk({6'h00, slope_capacitor_value_o, dcm_current_source_o},
			v[2] & 16'h03FF);
		chk({adaptive_bus_enable_o, 3'h0, adaptive_high_threshold_o,
			adaptive_low_threshold_o}, v[8] & 16'h8FFF);
		chk({8'h00, slew_resolution_o, transition_slew_limit_o},
			{8'h01, v[7][6:0]});
		chk({15'h0000, inductor_coupled_o}, {15'h0000, v[5][0]});
		for (k = 0; k < 4; k++)
			chk({4'h0, slot_page_o[k], 3'h0, slot_addr_o[k]}, {4'h0,
				v[3][4*k+3], 3'h0, 8'h18 + v[3][4*k+:3]});
		i_vrc_host.access(1'b1, 1'b0, 8'hC0, ~v[1]);
		rd(1'b0, 8'hC0, 16'h0000);
		rd(1'b1, 8'hC0, v[1]);
		wr(8'hC8, 16'hFFFF);
		rd(1'b1, 8'hC8, 16'h0000);
		for (i = 0; i < 8; i++) begin
			wr(8'hC1, 16'(i) << 10);
			tick(2);
			chk({7'h00, sense_gain_valid_o, rail2_sense_gain_o},
				{7'h00, i < 5, gt[i]});
			pgs = $random(seed);
			wr(8'hC4, 16'(i) << 2);
			tick(2);
			chk({15'h0000, good_pin_o}, {15'h0000, pgs[i]});
			rail_en_pin_i = $random(seed);
			wr(8'hC4, 16'(i[0]) << 5);
			tick(8);
			chk({14'h0000, rail_enable_o},
				{14'h0000, rail_en_pin_i ^ {2{i[0]}}});
		end
		for (i = 0; i < 24; i++) begin
			d = $random(seed);
			target_vid_i = $random(seed) & 22'h07F8FF;
			dac_vid_i = $random(seed) & 22'h07F8FF;
			{voltage_code_step_i, slewing_to_zero_i,
				slew_resolution_bit_i} = $random(seed);
			vin_volts_i = 5'h07 + 5'(i % 8);
			wr(8'hC5, d);
			tick(2);
			for (k = 0; k < 2; k++) begin
				lim = 11'(d[12:8]) << voltage_code_step_i;
				chk({14'h0000, rail_ramp_off_o[k], rail_good_block_o[k]},
					{14'h0000, {2{target_vid_i[k] < lim}}});
				lim = 11'(d[7:0]) << voltage_code_step_i;
				chk({15'h0000, pwm_hiz_o[k]}, {15'h0000, slewing_to_zero_i[k]
					&& dac_vid_i[k] < lim});
			end
			chk({15'h0000, ripple_detect_enable_o}, {15'h0000, !(d[15] &&
				vin_volts_i < 5'h08 + 5'(d[14:13]))});
			chk({15'h0000, slew_resolution_o},
				{15'h0000, slew_resolution_bit_i});
		end
		for (i = 0; i < 3; i++) begin
			k = i[0] ? 40 : 400;
			detect_time_scale_select_i = i[0];
			wr(8'hC4, i < 2 ? 16'h0900 : 16'h0100);
			phase_cs_low_i = 4'h5;
			tick(2 * k - 10);
			chk({12'h000, phase_abnormal_o}, 16'h0000);
			tick(70);
			chk({12'h000, phase_abnormal_o},
				i < 2 ? 16'h0005 : 16'h0000);
			phase_cs_low_i = 4'h0;
			tick(2);
			chk({12'h000, phase_abnormal_o}, 16'h0000);
		end
		wr(8'hC4, 16'h0800);
		phase_cs_low_i = 4'h1;
		tick(2);
		chk({12'h000, phase_abnormal_o}, 16'h0001);
		phase_cs_low_i = 4'h0;
		tick(2);
		chk({12'h000, phase_abnormal_o}, 16'h0000);
		chk(16'(q.size()), 16'h0000);
		final_report();
	end
endmodule // tb

//--- dv/vrc_host.sv
/*
 * Host model of the management bus side: one register access at a time.
 * Assumes the bench calls access and watches the read answer itself.
 */
module vrc_host (
	input  wire logic        clk_i,
	output logic             wr_o,
	output logic             rd_o,
	output logic             page_o,
	output logic [7:0]       addr_o,
	output logic [15:0]      wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		page_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 16'h0000;
	end
	// Released address and data lines show the inverse so a stale value is never trusted.
	task automatic access(input logic w, input logic p, input logic [7:0] a,
		input logic [15:0] d);
		@(negedge clk_i);
		page_o = p;
		addr_o = a;
		wdata_o = d;
		wr_o = w;
		rd_o = !w;
		@(negedge clk_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
endmodule // vrc_host
